// ### drfs_pkg.sv
// Shared constants and types for the memory rail fault supervisor
package drfs_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int DRFS_CLK_NS = 4;
  localparam int DRFS_TICK_NS = 2500;
  localparam int DRFS_TICK_DIV = DRFS_TICK_NS / DRFS_CLK_NS;
  localparam int DRFS_BLANK_NS = 150;
  localparam int DRFS_BLANK_CYC = (DRFS_BLANK_NS + DRFS_CLK_NS - 1) / DRFS_CLK_NS;
  localparam int DRFS_QUAL_TICKS = 4;
  localparam int DRFS_SS_TICKS = 128;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] DRFS_OFS_CTRL = 4'h0;
  localparam logic [3:0] DRFS_OFS_STATUS = 4'h4;
  localparam int DRFS_CTRL_FORCE_OFF = 0;
  localparam logic DRFS_CTRL_RST = 1'b0;
  localparam int DRFS_ST_STATE = 0;
  localparam int DRFS_ST_SGOOD = 2;
  localparam int DRFS_ST_OC = 3;
  localparam int DRFS_ST_OV = 4;
  localparam int DRFS_ST_UV = 5;
  localparam int DRFS_ST_HOT = 6;
  localparam int DRFS_ST_INREG = 7;
  localparam int DRFS_ST_TERM = 8;
  localparam int DRFS_ST_SSHI = 9;
  localparam int DRFS_ST_PSAVE = 10;
  localparam int DRFS_ST_PGPIN = 11;
  // ---------------------------------------------------------------
  // Synchronised input vector positions
  // ---------------------------------------------------------------
  localparam int IX_SUP_RISE = 0;
  localparam int IX_SUP_FALL = 1;
  localparam int IX_VIN = 2;
  localparam int IX_EN = 3;
  localparam int IX_TERM = 4;
  localparam int IX_FORCED_PWM_SELECT = 5;
  localparam int IX_OC_TRIP = 6;
  localparam int IX_PWM = 7;
  localparam int IX_A130 = 8;
  localparam int IX_A106 = 9;
  localparam int IX_ANOM = 10;
  localparam int IX_A112 = 11;
  localparam int IX_B88 = 12;
  localparam int IX_B94 = 13;
  localparam int IX_B65 = 14;
  localparam int IX_T150 = 15;
  localparam int IX_T125 = 16;
  localparam int DRFS_IN_W = 17;

  typedef enum logic [1:0] {
    DRFS_OFF = 2'b00,
    DRFS_FULL_ON = 2'b01,
    DRFS_STANDBY = 2'b10,
    DRFS_LATCHED = 2'b11
  } drfs_state_t;
endpackage

// ### drfs_supervisor.sv
// Fault supervision and output sequencing for the memory supply controller
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Sample overcurrent only with high-side gate on, after 150 ns blanking.
// - Four internal cycles of overcurrent trip set fault and latch outputs off.
// - Overcurrent latch clears only when supply or main enable cycles.
// - Termination regulator on in full-on only with enable and rail regulated.
// - Each termination off-to-on transition starts a soft-start.
// - Soft-start uses low current limit, high limit after 128 internal cycles.
// - Termination output stays high impedance in standby.
// - Half reference on while main enable high in full-on or standby, off in off and latched states.
// - Supply-good flag follows supply comparator with rising/falling hysteresis.
// - Supply failure in full-on with both enables high goes to off.
// - Over-temperature shuts down; resume only below lower threshold.
// - Window output driven low outside 12 percent window and in off or latched state, released inside in full-on or standby.
// - Between 106 and 130 percent: high-side off, low-side on until nominal.
// - Four internal cycles above 130 percent latch overvoltage fault, gates off.
// - Overvoltage latch clears on main enable, supply or input supply toggle.
// - Power-saving below 94 percent goes to max frequency until nominal.
// - Four internal cycles below 65 percent latch undervoltage fault, gates off.
// - Undervoltage latch clears on main enable, supply or input supply cycle.
// - State from inputs: off, full-on if termination enable, else standby.
// - Standby uses power-saving when forced-PWM select high, else forced PWM.
// - In-regulation flag raised when rail regulates in normal operation.
module drfs_supervisor import drfs_pkg::*; #(
  parameter int TICK_DIV = DRFS_TICK_DIV,
  parameter int SS_TICKS = DRFS_SS_TICKS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_analog_supply_above_rise,
  input wire logic i_analog_supply_above_fall,
  input wire logic i_overcurrent_sense_input,
  input wire logic i_main_rail_enable,
  input wire logic i_termination_enable,
  input wire logic i_forced_pwm_select,
  input wire logic i_switch_node_sense_trip,
  input wire logic i_pwm_demand,
  input wire logic i_rail_above_130,
  input wire logic i_rail_above_106,
  input wire logic i_rail_above_nominal,
  input wire logic i_rail_above_112,
  input wire logic i_rail_below_88,
  input wire logic i_rail_below_94,
  input wire logic i_rail_below_65,
  input wire logic i_temp_above_upper,
  input wire logic i_temp_above_lower,
  input wire logic i_output_in_window_in,
  output logic o_output_in_window_out,
  output logic o_output_in_window_oe,
  output logic o_high_side_gate,
  output logic o_low_side_gate,
  output logic o_memory_supply_rail_en,
  output logic o_buffered_half_reference_en,
  output logic o_termination_rail_en,
  output logic o_termination_limit_high,
  output logic o_power_saving,
  output logic o_supply_good_flag,
  output logic o_main_rail_in_regulation,
  output logic [1:0] o_state
);
  // ---------------------------------------------------------------
  // Sizes and checks
  // ---------------------------------------------------------------
  localparam int DIV_W = $clog2(TICK_DIV);
  localparam int BLK_W = $clog2(DRFS_BLANK_CYC + 1);
  localparam int SS_W = $clog2(SS_TICKS + 1);
  localparam logic [2:0] QUAL_LAST = 3'(DRFS_QUAL_TICKS - 1);

  generate
    if (TICK_DIV < 2 || SS_TICKS < 2) begin : g_bad_param
      $error("TICK_DIV and SS_TICKS must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DRFS_IN_W-1:0] sy1;
    logic [DRFS_IN_W-1:0] sy2;
    logic [DIV_W-1:0] div;
    logic tick;
    logic [BLK_W-1:0] blank;
    logic oc_seen;
    logic [2:0] oc_cnt;
    logic [2:0] ov_cnt;
    logic [2:0] uv_cnt;
    logic oc_flt;
    logic ov_flt;
    logic uv_flt;
    logic hot;
    logic sgood;
    logic discharge;
    logic boost;
    logic term_en;
    logic ss_high;
    logic [SS_W-1:0] ss_cnt;
    drfs_state_t state;
    logic hs;
    logic ls;
    logic pg_oe;
    logic ref_en;
    logic rail_en;
    logic psave;
    logic in_reg;
    logic force_off;
    logic wait_r;
    logic [31:0] rdata;
  } drfs_sv_t;

  drfs_sv_t st;
  drfs_sv_t nx;
  logic rst_s1;
  logic rst_s2;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [DRFS_IN_W-1:0] s;
  logic allow;
  logic run_ok;
  logic oc_win;
  logic clr_oc;
  logic clr_vv;
  logic req;

  always_comb begin
    nx = st;
    s = st.sy2;
    nx.sy1 = {i_temp_above_lower, i_temp_above_upper, i_rail_below_65,
              i_rail_below_94, i_rail_below_88, i_rail_above_112,
              i_rail_above_nominal, i_rail_above_106, i_rail_above_130,
              i_pwm_demand, i_switch_node_sense_trip, i_forced_pwm_select,
              i_termination_enable, i_main_rail_enable,
              i_overcurrent_sense_input, i_analog_supply_above_fall,
              i_analog_supply_above_rise};
    nx.sy2 = st.sy1;
    // Internal oscillator enable
    nx.tick = (st.div == DIV_W'(TICK_DIV - 1));
    nx.div = nx.tick ? '0 : st.div + 1'b1;
    // Supply good and thermal hysteresis
    if (s[IX_SUP_RISE]) begin
      nx.sgood = 1'b1;
    end else if (!s[IX_SUP_FALL]) begin
      nx.sgood = 1'b0;
    end
    if (s[IX_T150]) begin
      nx.hot = 1'b1;
    end else if (!s[IX_T125]) begin
      nx.hot = 1'b0;
    end
    run_ok = (st.state == DRFS_FULL_ON || st.state == DRFS_STANDBY) &&
             !st.oc_flt && !st.ov_flt && !st.uv_flt;
    allow = st.sgood && s[IX_VIN] && s[IX_EN] && !st.hot && !st.force_off;
    // State selection
    if (!allow) begin
      nx.state = DRFS_OFF;
    end else if (st.oc_flt || st.ov_flt || st.uv_flt) begin
      nx.state = DRFS_LATCHED;
    end else begin
      nx.state = s[IX_TERM] ? DRFS_FULL_ON : DRFS_STANDBY;
    end
    // Overcurrent blanking and qualification
    nx.blank = st.hs ? ((st.blank == BLK_W'(DRFS_BLANK_CYC)) ? st.blank
                                                            : st.blank + 1'b1) : '0;
    oc_win = run_ok && st.hs && (st.blank == BLK_W'(DRFS_BLANK_CYC));
    if (st.tick) begin
      nx.oc_seen = oc_win && s[IX_OC_TRIP];
    end else if (oc_win && s[IX_OC_TRIP]) begin
      nx.oc_seen = 1'b1;
    end
    if (!run_ok) begin
      nx.oc_cnt = '0;
      nx.ov_cnt = '0;
      nx.uv_cnt = '0;
    end else if (st.tick) begin
      nx.oc_cnt = (st.oc_seen || (oc_win && s[IX_OC_TRIP])) ? st.oc_cnt + 1'b1 : '0;
      nx.ov_cnt = s[IX_A130] ? st.ov_cnt + 1'b1 : '0;
      nx.uv_cnt = s[IX_B65] ? st.uv_cnt + 1'b1 : '0;
    end
    // Fault latches, set wins over clear
    clr_oc = !st.sgood || !s[IX_EN];
    clr_vv = clr_oc || !s[IX_VIN];
    if (clr_oc) begin
      nx.oc_flt = 1'b0;
    end
    if (clr_vv) begin
      nx.ov_flt = 1'b0;
      nx.uv_flt = 1'b0;
    end
    if (run_ok && st.tick) begin
      if (st.oc_cnt == QUAL_LAST && (st.oc_seen || (oc_win && s[IX_OC_TRIP]))) begin
        nx.oc_flt = 1'b1;
      end
      if (st.ov_cnt == QUAL_LAST && s[IX_A130]) begin
        nx.ov_flt = 1'b1;
      end
      if (st.uv_cnt == QUAL_LAST && s[IX_B65]) begin
        nx.uv_flt = 1'b1;
      end
    end
    // Overvoltage discharge and undervoltage frequency boost
    if (run_ok && s[IX_A106]) begin
      nx.discharge = 1'b1;
    end else if (!run_ok || !s[IX_ANOM]) begin
      nx.discharge = 1'b0;
    end
    if (st.psave && s[IX_B94]) begin
      nx.boost = 1'b1;
    end else if (s[IX_ANOM] || st.state != DRFS_STANDBY || !s[IX_FORCED_PWM_SELECT]) begin
      nx.boost = 1'b0;
    end
    nx.psave = run_ok && st.state == DRFS_STANDBY && s[IX_FORCED_PWM_SELECT] && !st.boost;
    // Gate drive
    if (!run_ok) begin
      nx.hs = 1'b0;
      nx.ls = 1'b0;
    end else if (st.discharge) begin
      nx.hs = 1'b0;
      nx.ls = 1'b1;
    end else begin
      nx.hs = s[IX_PWM];
      nx.ls = !s[IX_PWM];
    end
    nx.rail_en = run_ok;
    nx.ref_en = run_ok && s[IX_EN];
    nx.in_reg = run_ok && !s[IX_B94] && !s[IX_A106];
    nx.pg_oe = !(run_ok && !s[IX_A112] && !s[IX_B88]);
    // Termination regulator and soft-start
    nx.term_en = run_ok && st.state == DRFS_FULL_ON && s[IX_TERM] && st.in_reg;
    if (!st.term_en && nx.term_en) begin
      nx.ss_cnt = '0;
      nx.ss_high = 1'b0;
    end else if (!st.term_en) begin
      nx.ss_high = 1'b0;
    end else if (!st.ss_high && st.tick) begin
      nx.ss_cnt = st.ss_cnt + 1'b1;
      nx.ss_high = (st.ss_cnt == SS_W'(SS_TICKS - 1));
    end
    // Register slave
    req = i_avs_read || i_avs_write;
    nx.wait_r = !(req && st.wait_r);
    if (req && st.wait_r) begin
      nx.rdata = '0;
      if (i_avs_read && i_avs_address == DRFS_OFS_CTRL) begin
        nx.rdata[DRFS_CTRL_FORCE_OFF] = st.force_off;
      end else if (i_avs_read && i_avs_address == DRFS_OFS_STATUS) begin
        nx.rdata[DRFS_ST_STATE +: 2] = st.state;
        nx.rdata[DRFS_ST_SGOOD] = st.sgood;
        nx.rdata[DRFS_ST_OC] = st.oc_flt;
        nx.rdata[DRFS_ST_OV] = st.ov_flt;
        nx.rdata[DRFS_ST_UV] = st.uv_flt;
        nx.rdata[DRFS_ST_HOT] = st.hot;
        nx.rdata[DRFS_ST_INREG] = st.in_reg;
        nx.rdata[DRFS_ST_TERM] = st.term_en;
        nx.rdata[DRFS_ST_SSHI] = st.ss_high;
        nx.rdata[DRFS_ST_PSAVE] = st.psave;
        nx.rdata[DRFS_ST_PGPIN] = i_output_in_window_in;
      end
    end
    if (i_avs_write && !st.wait_r && i_avs_address == DRFS_OFS_CTRL &&
        i_avs_byteenable[0]) begin
      nx.force_off = i_avs_writedata[DRFS_CTRL_FORCE_OFF];
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_s2) begin
    if (!rst_s2) begin
      st <= '0;
      st.state <= DRFS_OFF;
      st.pg_oe <= 1'b1;
      st.force_off <= DRFS_CTRL_RST;
      st.wait_r <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign o_avs_readdata = st.rdata;
  assign o_avs_waitrequest = st.wait_r;
  assign o_output_in_window_out = 1'b0;
  assign o_output_in_window_oe = st.pg_oe;
  assign o_high_side_gate = st.hs;
  assign o_low_side_gate = st.ls;
  assign o_memory_supply_rail_en = st.rail_en;
  assign o_buffered_half_reference_en = st.ref_en;
  assign o_termination_rail_en = st.term_en;
  assign o_termination_limit_high = st.ss_high;
  assign o_power_saving = st.psave;
  assign o_supply_good_flag = st.sgood;
  assign o_main_rail_in_regulation = st.in_reg;
  assign o_state = st.state;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_s2);

  blank_window_a: assert property ($rose(st.oc_seen) |-> $past(st.hs) &&
      $past(st.blank) == BLK_W'(DRFS_BLANK_CYC)) else $error("trip sampled in blanking");
  oc_latch_a: assert property (st.oc_flt |=> !st.hs && !st.ls && !st.rail_en)
    else $error("outputs not off after overcurrent");
  oc_hold_a: assert property (st.oc_flt && st.sgood && st.sy2[IX_EN] |=> st.oc_flt)
    else $error("overcurrent latch lost");
  term_state_a: assert property (st.term_en |-> $past(st.state) == DRFS_FULL_ON &&
      $past(st.in_reg)) else $error("termination on outside full-on");
  ss_start_a: assert property ($rose(st.term_en) |-> !st.ss_high && st.ss_cnt == '0)
    else $error("soft-start not restarted");
  ss_step_a: assert property ($rose(st.ss_high) |-> $past(st.tick) &&
      $past(st.ss_cnt) == SS_W'(SS_TICKS - 1)) else $error("limit raised at wrong count");
  standby_hiz_a: assert property (st.state == DRFS_STANDBY |=> !st.term_en)
    else $error("termination driven in standby");
  ref_off_a: assert property (st.state == DRFS_OFF |=> !st.ref_en && !st.rail_en)
    else $error("reference on in off state");
  sgood_hyst_a: assert property ($fell(st.sgood) |-> !$past(st.sy2[IX_SUP_FALL]))
    else $error("supply good dropped above falling level");
  hot_off_a: assert property (st.hot |=> st.state == DRFS_OFF)
    else $error("running while hot");
  pg_low_a: assert property (st.state == DRFS_OFF |=> st.pg_oe)
    else $error("window output released while off");
  ov_clamp_a: assert property (st.discharge && !st.oc_flt && !st.ov_flt && !st.uv_flt &&
      st.state != DRFS_OFF && st.state != DRFS_LATCHED |=> !st.hs && st.ls)
    else $error("discharge not applied");
  ov_qual_a: assert property ($rose(st.ov_flt) |-> $past(st.ov_cnt) == QUAL_LAST)
    else $error("overvoltage set early");
  uv_qual_a: assert property ($rose(st.uv_flt) |-> $past(st.uv_cnt) == QUAL_LAST)
    else $error("undervoltage set early");
  supply_off_a: assert property (!st.sgood |=> st.state == DRFS_OFF)
    else $error("running without supply good");
  boost_max_a: assert property (st.boost |=> !st.psave)
    else $error("power saving kept during boost");
  psave_mode_a: assert property (st.psave |-> $past(st.state) == DRFS_STANDBY &&
      $past(st.sy2[IX_FORCED_PWM_SELECT])) else $error("power saving outside standby select");
  inreg_run_a: assert property (st.in_reg |->
      $past(st.state) inside {DRFS_FULL_ON, DRFS_STANDBY}) else $error("in regulation while off");

  oc_trip_c: cover property ($rose(st.oc_flt));
  ss_done_c: cover property ($rose(st.ss_high));
  psave_c: cover property (st.state == DRFS_STANDBY && st.psave);
  boost_c: cover property ($rose(st.boost));
  discharge_c: cover property ($rose(st.discharge));
endmodule

`default_nettype wire

// ### drfs_analog_model.sv
// Behavioural model of the rail comparators, supplies and window pull-up
`timescale 1ns/100ps
`default_nettype none
module drfs_analog_model (
  input wire logic [7:0] i_rail_pct,
  input wire logic [1:0] i_sup_lvl,
  input wire logic [1:0] i_tmp_lvl,
  input wire logic i_short,
  input wire logic i_rail_en,
  input wire logic i_pin_oe,
  output logic o_sup_rise,
  output logic o_sup_fall,
  output logic o_pwm,
  output logic o_trip,
  output logic o_a130,
  output logic o_a106,
  output logic o_anom,
  output logic o_a112,
  output logic o_b88,
  output logic o_b94,
  output logic o_b65,
  output logic o_t_up,
  output logic o_t_lo,
  output logic o_pin
);
  // ---------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------
  // Rising supply level sits above the falling one
  assign o_sup_rise = i_sup_lvl >= 2'd2;
  assign o_sup_fall = i_sup_lvl >= 2'd1;
  assign o_pwm = i_rail_en;
  // Sense trips whenever shorted, whichever switch conducts
  assign o_trip = i_short;
  assign o_a130 = i_rail_pct > 8'd130;
  assign o_a106 = i_rail_pct > 8'd106;
  assign o_anom = i_rail_pct > 8'd100;
  assign o_a112 = i_rail_pct > 8'd112;
  assign o_b88 = i_rail_pct < 8'd88;
  assign o_b94 = i_rail_pct < 8'd94;
  assign o_b65 = i_rail_pct < 8'd65;
  assign o_t_up = i_tmp_lvl >= 2'd2;
  assign o_t_lo = i_tmp_lvl >= 2'd1;
  // Pull-up on the open-drain window pin
  assign o_pin = i_pin_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### drfs_supervisor_tb_top.sv
// Self-checking bench for the memory rail fault supervisor
`timescale 1ns/100ps
`default_nettype none
module drfs_supervisor_tb_top;
  import drfs_pkg::*;
  localparam int TD = 4;
  localparam int SS = 4;
  logic clk, rst_n, rd, wr, en, ten, forced_pwm_select, converter_input_supply, shrt, wreq;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] pct;
  logic [1:0] sup, tmp, st;
  logic sr, sf, pwm, trip, a130, a106, anom, a112, b88, b94, b65, tu, tl, pin;
  logic pout, poe, hg, lg, ren, vref, tren, lim, ps, sg, inreg;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed;

  drfs_supervisor #(.TICK_DIV(TD), .SS_TICKS(SS)) i_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_analog_supply_above_rise(sr), .i_analog_supply_above_fall(sf),
    .i_overcurrent_sense_input(converter_input_supply), .i_main_rail_enable(en), .i_termination_enable(ten),
    .i_forced_pwm_select(forced_pwm_select), .i_switch_node_sense_trip(trip), .i_pwm_demand(pwm),
    .i_rail_above_130(a130), .i_rail_above_106(a106), .i_rail_above_nominal(anom),
    .i_rail_above_112(a112), .i_rail_below_88(b88), .i_rail_below_94(b94),
    .i_rail_below_65(b65), .i_temp_above_upper(tu), .i_temp_above_lower(tl),
    .i_output_in_window_in(pin), .o_output_in_window_out(pout), .o_output_in_window_oe(poe),
    .o_high_side_gate(hg), .o_low_side_gate(lg), .o_memory_supply_rail_en(ren),
    .o_buffered_half_reference_en(vref), .o_termination_rail_en(tren),
    .o_termination_limit_high(lim), .o_power_saving(ps), .o_supply_good_flag(sg),
    .o_main_rail_in_regulation(inreg), .o_state(st));

  drfs_analog_model i_model (
    .i_rail_pct(pct), .i_sup_lvl(sup), .i_tmp_lvl(tmp), .i_short(shrt), .i_rail_en(ren),
    .i_pin_oe(poe), .o_sup_rise(sr), .o_sup_fall(sf), .o_pwm(pwm), .o_trip(trip),
    .o_a130(a130), .o_a106(a106), .o_anom(anom), .o_a112(a112), .o_b88(b88), .o_b94(b94),
    .o_b65(b65), .o_t_up(tu), .o_t_lo(tl), .o_pin(pin));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    q_msk.push_back(m);
    q_exp.push_back(e);
    bus(1'b0, a, $urandom);
  endtask

  task automatic stat(input logic [1:0] s, input int b, input logic v);
    rd_chk(DRFS_OFS_STATUS, 32'h3 | (32'h1 << b), 32'(s) | (32'(v) << b));
  endtask

  task automatic wait_st(input logic [1:0] s);
    int t;
    t = 0;
    while (st !== s && t < 400) begin
      @(posedge clk);
      t++;
    end
    repeat (3) @(posedge clk);
    cmp("state", 32'(s), 32'(st));
  endtask

  task automatic settle;
    repeat (40) @(posedge clk);
  endtask

  // Drop one of the restart inputs, then raise it again
  task automatic recycle(input int k);
    case (k)
      0: converter_input_supply <= 1'b0;
      1: en <= 1'b0;
      default: sup <= 2'd0;
    endcase
    settle;
    converter_input_supply <= 1'b1;
    en <= 1'b1;
    sup <= 2'd2;
  endtask

  task automatic done_t(input string nm);
    $display("test %s finished", nm);
  endtask

  // ---------------------------------------------------------------
  // Clock, timeout and read monitor
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end

  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && q_exp.size() > 0) begin
      cmp("readdata", q_exp[0], rdata & q_msk[0]);
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, rd, wr, en, ten, forced_pwm_select, converter_input_supply, shrt} = 8'h00;
    {addr, wdata, pct, sup, tmp} = '0;
    seed = $urandom(54651);
    repeat (6) @(posedge clk);
    cmp("oe_reset", 1, poe);
    cmp("wait_reset", 1, wreq);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    converter_input_supply <= 1'b1;
    sup <= 2'd2;
    en <= 1'b1;
    forced_pwm_select <= 1'b1;
    pct <= 8'd100 + 8'($urandom % 6);
    wait_st(DRFS_STANDBY);
    cmp("ps", 1, ps);
    cmp("term", 0, tren);
    cmp("ref", 1, vref);
    stat(DRFS_STANDBY, DRFS_ST_SGOOD, 1'b1);
    pct <= 8'd90;
    settle;
    cmp("ps_boost", 0, ps);
    pct <= 8'd101;
    settle;
    cmp("ps_back", 1, ps);
    forced_pwm_select <= 1'b0;
    settle;
    cmp("ps_forced_pwm_select", 0, ps);
    done_t("standby");
    ten <= 1'b1;
    wait_st(DRFS_FULL_ON);
    cmp("term_on", 1, tren);
    cmp("lim_lo", 0, lim);
    cmp("inreg", 1, inreg);
    repeat (SS * TD + 3 * TD) @(posedge clk);
    cmp("lim_hi", 1, lim);
    ten <= 1'b0;
    wait_st(DRFS_STANDBY);
    ten <= 1'b1;
    wait_st(DRFS_FULL_ON);
    cmp("lim_restart", 0, lim);
    done_t("soft_start");
    pct <= 8'd115;
    shrt <= 1'b1;
    repeat (150) @(posedge clk);
    cmp("win_low", 1, poe);
    cmp("pin", 0, pin);
    cmp("pin_drive", 0, pout);
    cmp("ov_gates", 32'h1, {hg, lg});
    cmp("no_oc", DRFS_FULL_ON, st);
    shrt <= 1'b0;
    pct <= 8'd100;
    settle;
    cmp("win_rel", 0, poe);
    cmp("hg_back", 1, hg);
    pct <= 8'd135;
    repeat (6) @(posedge clk);
    pct <= 8'd100;
    settle;
    cmp("ov_short", DRFS_FULL_ON, st);
    done_t("window");
    for (int k = 0; k < 3; k++) begin
      pct <= 8'd135;
      wait_st(DRFS_LATCHED);
      cmp("ov_off", 0, {hg, lg});
      stat(DRFS_LATCHED, DRFS_ST_OV, 1'b1);
      pct <= 8'd100;
      recycle(k);
      wait_st(DRFS_FULL_ON);
      stat(DRFS_FULL_ON, DRFS_ST_OV, 1'b0);
      pct <= 8'd60;
      wait_st(DRFS_LATCHED);
      cmp("uv_off", 0, {hg, lg});
      stat(DRFS_LATCHED, DRFS_ST_UV, 1'b1);
      pct <= 8'd100;
      recycle(k);
      wait_st(DRFS_FULL_ON);
      shrt <= 1'b1;
      wait_st(DRFS_LATCHED);
      stat(DRFS_LATCHED, DRFS_ST_OC, 1'b1);
      cmp("oc_off", 0, {hg, lg, ren, vref, tren});
      shrt <= 1'b0;
      recycle(k);
      settle;
      cmp("oc_clear", k == 0 ? DRFS_LATCHED : DRFS_FULL_ON, st);
      if (k == 0) begin
        recycle(1);
        wait_st(DRFS_FULL_ON);
      end
    end
    done_t("latches");
    sup <= 2'd1;
    settle;
    cmp("sg_hold", 1, sg);
    sup <= 2'd0;
    wait_st(DRFS_OFF);
    cmp("off_out", 32'h1, {sg, vref, hg, lg, poe});
    sup <= 2'd1;
    settle;
    cmp("sg_low", 0, sg);
    sup <= 2'd2;
    wait_st(DRFS_FULL_ON);
    tmp <= 2'd2;
    wait_st(DRFS_OFF);
    tmp <= 2'd1;
    settle;
    cmp("hot_hold", DRFS_OFF, st);
    tmp <= 2'd0;
    wait_st(DRFS_FULL_ON);
    done_t("supply_thermal");
    bus(1'b1, DRFS_OFS_CTRL, 32'($urandom) | 32'h1);
    wait_st(DRFS_OFF);
    rd_chk(DRFS_OFS_CTRL, 32'h1, 32'h1);
    rd_chk(4'h8 + 4'(4 * ($urandom % 2)), 32'hffffffff, 32'h0);
    bus(1'b1, 4'hc, $urandom);
    bus(1'b1, DRFS_OFS_CTRL, 32'h0);
    wait_st(DRFS_FULL_ON);
    done_t("registers");
    repeat (5) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire
